// ### hw/logic_cell_defs.vh
// constants for the configurable logic cell
// Function
// - cell runs on selected inputs, also asleep
// - fast oscillator kept on when enabled and selected
// - cpu idles while cell keeps running
// - enable bit seven, clear forces output zero
// - control bit five reads final output
// - rise enable lets rising edge set flag
// - fall enable lets falling edge set flag
// - modes 000 to 010 combinational functions, 011 SR latch
// - modes 100 to 111 sequential functions
// - polarity bit seven inverts output, 6-4 zero
// - polarity bits 0-3 invert gates 1-4
// - select registers six-bit field, top zero
// - gate one enables true/negated per data
// - gates two to four same layout
// - select, gate, gate polarity keep through reset
// - control bit six reads zero
// - gate ANDs all enabled data terms
// - empty gate gives its polarity bit
// - reset clears control and output polarity bit, keeps the rest of configuration
// - polarity change edge raises flag
`ifndef LOGIC_CELL_DEFS_VH
`define LOGIC_CELL_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_CELL_CONTROL   4'h0
`define ADDR_CELL_POLARITY  4'h1
`define ADDR_INPUT_ONE_SEL  4'h2
`define ADDR_GATE_ONE_EN    4'h6
`define ADDR_CELL_STATUS    4'hA

// ****************************************
// field positions
// ****************************************
`define CTRL_ENABLE_BIT     7
`define CTRL_OUT_BIT        5
`define CTRL_RISE_BIT       4
`define CTRL_FALL_BIT       3
`define POL_OUTPUT_BIT      7
`define STATUS_FLAG_BIT     0

// ****************************************
// reset values and codes
// ****************************************
`define CELL_CONTROL_RESET  8'h00
`define FAST_OSC_SRC_CODE   6'h34
`define MODE_AND_OR         3'h0
`define MODE_OR_XOR         3'h1
`define MODE_AND4           3'h2
`define MODE_SR_LATCH       3'h3
`define MODE_DFF_SR         3'h4
`define MODE_DFF2_R         3'h5
`define MODE_JK_R           3'h6
`define MODE_LATCH_SR       3'h7

`endif

// ### hw/configurable_logic_cell.v
// configurable logic cell: input select, gates, function, edge flag
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_defs.vh"

module configurable_logic_cell (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [3:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWrEn,
    input  wire        regRdEn,
    output reg  [7:0]  regRdData_ff,
    input  wire [63:0] cellSrc,
    input  wire        sleepReq,
    output reg         cellOut_ff,
    output reg         cellIrqFlag_ff,
    output reg         fastOscKeepOn_ff,
    output reg         cpuIdle_ff
);

    // ****************************************
    // register storage
    // ****************************************
    reg        enable_ff;
    reg        riseIrqEn_ff;
    reg        fallIrqEn_ff;
    reg [2:0]  mode_ff;
    reg        outputInvert_ff;
    reg [3:0]  gateInvert_ff;
    reg [5:0]  srcSel_ff [0:3];
    reg [7:0]  gateEn_ff [0:3];

    reg [63:0] srcMeta_ff;
    reg [63:0] srcSync_ff;
    reg        stateQ_ff;
    reg        g1Prev_ff;
    reg        prevOut_ff;

    wire [3:0] dataIn;
    wire [3:0] gateOut;
    wire [3:0] selIsFastOsc;
    reg        combOut;
    reg        logicOut;
    reg        nxt_stateQ;
    reg        nxt_cellOut;
    reg        nxt_flag;
    reg [7:0]  nxt_rdData;
    wire       g1Rise;
    wire       riseEdge;
    wire       fallEdge;
    wire       flagClear;
    wire       wrControl;
    wire       wrPolarity;

    // ****************************************
    // address decode
    // ****************************************
    assign wrControl  = regWrEn && (regAddr == `ADDR_CELL_CONTROL);
    assign wrPolarity = regWrEn && (regAddr == `ADDR_CELL_POLARITY);

    // ****************************************
    // control register and output polarity bit, cleared by any reset
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff       <= 1'b0;
            riseIrqEn_ff    <= 1'b0;
            fallIrqEn_ff    <= 1'b0;
            mode_ff         <= 3'h0;
            outputInvert_ff <= 1'b0;
        end else begin
            if (wrControl) begin
                enable_ff    <= regWrData[`CTRL_ENABLE_BIT];
                riseIrqEn_ff <= regWrData[`CTRL_RISE_BIT];
                fallIrqEn_ff <= regWrData[`CTRL_FALL_BIT];
                mode_ff      <= regWrData[2:0];
            end
            if (wrPolarity) begin
                outputInvert_ff <= regWrData[`POL_OUTPUT_BIT];
            end
        end
    end

    // ****************************************
    // configuration, untouched by reset
    // ****************************************
    // power-up contents unknown, kept across resets
    always @(posedge core_clk) begin
        if (wrPolarity) begin
            gateInvert_ff <= regWrData[3:0];
        end
    end

    // ****************************************
    // input lanes and data gates
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_lane
            // lane addresses, cut to the bus width on use
            localparam integer SEL_ADDR  = `ADDR_INPUT_ONE_SEL + i;
            localparam integer GATE_ADDR = `ADDR_GATE_ONE_EN + i;

            always @(posedge core_clk) begin
                if (regWrEn && (regAddr == SEL_ADDR[3:0])) begin
                    srcSel_ff[i] <= regWrData[5:0];
                end
                if (regWrEn && (regAddr == GATE_ADDR[3:0])) begin
                    gateEn_ff[i] <= regWrData;
                end
            end

            assign dataIn[i] = srcSync_ff[srcSel_ff[i]];
            assign selIsFastOsc[i] = (srcSel_ff[i] == `FAST_OSC_SRC_CODE);

            // bits 2k+1 / 2k enable data k+1 true / negated
            wire [7:0] en;
            wire [7:0] term;
            assign en = gateEn_ff[i];
            assign term[7] = ~en[7] | dataIn[3];
            assign term[6] = ~en[6] | ~dataIn[3];
            assign term[5] = ~en[5] | dataIn[2];
            assign term[4] = ~en[4] | ~dataIn[2];
            assign term[3] = ~en[3] | dataIn[1];
            assign term[2] = ~en[2] | ~dataIn[1];
            assign term[1] = ~en[1] | dataIn[0];
            assign term[0] = ~en[0] | ~dataIn[0];
            // empty gate yields zero before inversion
            assign gateOut[i] = ((|en) & (&term)) ^ gateInvert_ff[i];
        end
    endgenerate

    // ****************************************
    // input synchroniser
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            srcMeta_ff <= 64'h0000_0000_0000_0000;
            srcSync_ff <= 64'h0000_0000_0000_0000;
        end else begin
            srcMeta_ff <= cellSrc;
            srcSync_ff <= srcMeta_ff;
        end
    end

    // ****************************************
    // logic function
    // ****************************************
    always @* begin
        case (mode_ff)
            `MODE_AND_OR: begin
                combOut = (gateOut[0] & gateOut[1]) | (gateOut[2] & gateOut[3]);
            end
            `MODE_OR_XOR: begin
                combOut = (gateOut[0] | gateOut[1]) ^ (gateOut[2] | gateOut[3]);
            end
            `MODE_AND4: begin
                combOut = &gateOut;
            end
            default: begin
                combOut = 1'b0;
            end
        endcase
    end

    // ****************************************
    // sequential functions
    // ****************************************
    assign g1Rise = gateOut[0] & ~g1Prev_ff;

    // gate1 clock/enable, gate2 data/J, gate3 reset, gate4 set/K or second data; SR latch: gates 1|2 set, 3|4 reset
    always @* begin
        nxt_stateQ = stateQ_ff;
        case (mode_ff)
            `MODE_SR_LATCH: begin
                if (gateOut[2] | gateOut[3]) begin
                    nxt_stateQ = 1'b0;
                end else if (gateOut[0] | gateOut[1]) begin
                    nxt_stateQ = 1'b1;
                end
            end
            `MODE_DFF_SR: begin
                if (gateOut[2]) begin
                    nxt_stateQ = 1'b0;
                end else if (gateOut[3]) begin
                    nxt_stateQ = 1'b1;
                end else if (g1Rise) begin
                    nxt_stateQ = gateOut[1];
                end
            end
            `MODE_DFF2_R: begin
                if (gateOut[2]) begin
                    nxt_stateQ = 1'b0;
                end else if (g1Rise) begin
                    nxt_stateQ = gateOut[1] & gateOut[3];
                end
            end
            `MODE_JK_R: begin
                if (gateOut[2]) begin
                    nxt_stateQ = 1'b0;
                end else if (g1Rise) begin
                    case ({gateOut[1], gateOut[3]})
                        2'b10: begin
                            nxt_stateQ = 1'b1;
                        end
                        2'b01: begin
                            nxt_stateQ = 1'b0;
                        end
                        2'b11: begin
                            nxt_stateQ = ~stateQ_ff;
                        end
                        default: begin
                            nxt_stateQ = stateQ_ff;
                        end
                    endcase
                end
            end
            `MODE_LATCH_SR: begin
                if (gateOut[2]) begin
                    nxt_stateQ = 1'b0;
                end else if (gateOut[3]) begin
                    nxt_stateQ = 1'b1;
                end else if (gateOut[0]) begin
                    nxt_stateQ = gateOut[1];
                end
            end
            default: begin
                nxt_stateQ = 1'b0;
            end
        endcase
        if (!enable_ff) begin
            nxt_stateQ = 1'b0;
        end
    end

    // ****************************************
    // function select
    // ****************************************
    // sequential modes and the latch show the state bit
    always @* begin
        if (mode_ff[2] || (mode_ff == `MODE_SR_LATCH)) begin
            logicOut = stateQ_ff;
        end else begin
            logicOut = combOut;
        end
    end

    // ****************************************
    // output stage
    // ****************************************
    always @* begin
        if (enable_ff) begin
            nxt_cellOut = logicOut ^ outputInvert_ff;
        end else begin
            nxt_cellOut = 1'b0;
        end
    end

    // ****************************************
    // edge detect and sticky flag
    // ****************************************
    // edges seen one cycle after the output register
    assign riseEdge  = riseIrqEn_ff & cellOut_ff & ~prevOut_ff;
    assign fallEdge  = fallIrqEn_ff & ~cellOut_ff & prevOut_ff;
    assign flagClear = regWrEn && (regAddr == `ADDR_CELL_STATUS)
                       && regWrData[`STATUS_FLAG_BIT];

    always @* begin
        nxt_flag = cellIrqFlag_ff;
        if (flagClear) begin
            nxt_flag = 1'b0;
        end
        if (riseEdge || fallEdge) begin
            nxt_flag = 1'b1;
        end
    end

    // ****************************************
    // state and output registers
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ_ff        <= 1'b0;
            g1Prev_ff        <= 1'b0;
            cellOut_ff       <= 1'b0;
            prevOut_ff       <= 1'b0;
            cellIrqFlag_ff   <= 1'b0;
        end else begin
            stateQ_ff        <= nxt_stateQ;
            g1Prev_ff        <= gateOut[0];
            cellOut_ff       <= nxt_cellOut;
            prevOut_ff       <= cellOut_ff;
            cellIrqFlag_ff   <= nxt_flag;
        end
    end

    // ****************************************
    // sleep: oscillator hold and cpu idle
    // ****************************************
    // oscillator held only while the cell can use it
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fastOscKeepOn_ff <= 1'b0;
            cpuIdle_ff       <= 1'b0;
        end else begin
            fastOscKeepOn_ff <= enable_ff & (|selIsFastOsc);
            cpuIdle_ff       <= sleepReq;
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    always @* begin
        nxt_rdData = 8'h00;
        case (regAddr)
            `ADDR_CELL_CONTROL: begin
                nxt_rdData = {enable_ff, 1'b0, cellOut_ff, riseIrqEn_ff,
                              fallIrqEn_ff, mode_ff};
            end
            `ADDR_CELL_POLARITY: begin
                nxt_rdData = {outputInvert_ff, 3'h0, gateInvert_ff};
            end
            4'h2: begin
                nxt_rdData = {2'h0, srcSel_ff[0]};
            end
            4'h3: begin
                nxt_rdData = {2'h0, srcSel_ff[1]};
            end
            4'h4: begin
                nxt_rdData = {2'h0, srcSel_ff[2]};
            end
            4'h5: begin
                nxt_rdData = {2'h0, srcSel_ff[3]};
            end
            4'h6: begin
                nxt_rdData = gateEn_ff[0];
            end
            4'h7: begin
                nxt_rdData = gateEn_ff[1];
            end
            4'h8: begin
                nxt_rdData = gateEn_ff[2];
            end
            4'h9: begin
                nxt_rdData = gateEn_ff[3];
            end
            `ADDR_CELL_STATUS: begin
                nxt_rdData = {7'h00, cellIrqFlag_ff};
            end
            default: begin
                nxt_rdData = 8'h00;
            end
        endcase
    end

    // ****************************************
    // read data register
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData_ff <= 8'h00;
        end else if (regRdEn) begin
            regRdData_ff <= nxt_rdData;
        end else begin
            regRdData_ff <= 8'h00;
        end
    end

endmodule // configurable_logic_cell
`default_nettype wire

// ### tb/source_model.sv
// source model: pin and peripheral levels plus fast oscillator
`timescale 1ns/1ps
`default_nettype none
module source_model (
    input  wire logic        core_clk,
    input  wire logic [63:0] srcLevel,
    input  wire logic        oscRun,
    output logic      [63:0] cellSrc
);
    logic oscPhase_ff = 1'b0;
    // oscillator stands still once nobody keeps it running
    always @(posedge core_clk) oscPhase_ff <= oscRun ? ~oscPhase_ff : 1'b0;
    assign cellSrc = {srcLevel[63:53], oscPhase_ff, srcLevel[51:0]};
endmodule // source_model
`default_nettype wire

// ### tb/logic_cell_checker.sv
// checker: port-level assertions for the logic cell
`timescale 1ns/1ps
`default_nettype none
module logic_cell_checker (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData_ff,
    input wire logic       cellOut_ff,
    input wire logic       cellIrqFlag_ff
);
    logic [7:0] ctlMirror_ff;
    // shadow of the control register, cleared by reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) ctlMirror_ff <= 8'h00;
        else if (regWrEn && regAddr == 4'h0) ctlMirror_ff <= regWrData;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_ctlRead;
        $past(regRdEn) && $past(regAddr) == 4'h0;
    endsequence
    sequence s_rise;
        $rose(cellOut_ff) && ctlMirror_ff[4];
    endsequence
    sequence s_fall;
        $fell(cellOut_ff) && ctlMirror_ff[3];
    endsequence
    a_ctl_bit6_zero: assert property (s_ctlRead |-> !regRdData_ff[6]) else $error("ctl bit6 set");
    a_ctl_out_copy: assert property (s_ctlRead |-> regRdData_ff[5] == $past(cellOut_ff))
        else $error("ctl out bit wrong");
    a_pol_gap_zero: assert property ($past(regRdEn) && $past(regAddr) == 4'h1 |->
        regRdData_ff[6:4] == 3'h0) else $error("pol gap set");
    a_sel_top_zero: assert property ($past(regRdEn) && $past(regAddr) inside {[4'h2:4'h5]} |->
        regRdData_ff[7:6] == 2'h0) else $error("select top set");
    a_rise_sets_flag: assert property (s_rise |=> cellIrqFlag_ff) else $error("rise missed");
    a_fall_sets_flag: assert property (s_fall |=> cellIrqFlag_ff) else $error("fall missed");
    a_flag_holds: assert property (cellIrqFlag_ff && !(regWrEn && regAddr == 4'hA && regWrData[0])
        |=> cellIrqFlag_ff) else $error("flag dropped");
    a_off_low: assert property (!ctlMirror_ff[7] && !$past(ctlMirror_ff[7]) |-> !cellOut_ff)
        else $error("output high while off");
endmodule // logic_cell_checker
bind configurable_logic_cell logic_cell_checker checker_i (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData_ff(regRdData_ff), .cellOut_ff(cellOut_ff), .cellIrqFlag_ff(cellIrqFlag_ff));
`default_nettype wire

// ### tb/configurable_logic_cell_tb.sv
// self-checking testbench for the configurable logic cell
`timescale 1ns/1ps
`default_nettype none
module configurable_logic_cell_tb;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWrData = 8'h00;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [63:0] srcLevel = 64'h0;
    logic        sleepReq = 1'b0;
    wire  [7:0]  regRdData_ff;
    wire  [63:0] cellSrc;
    wire         cellOut_ff, cellIrqFlag_ff, fastOscKeepOn_ff, cpuIdle_ff;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    always #4 core_clk = ~core_clk;
    source_model srcModel (.core_clk(core_clk), .srcLevel(srcLevel),
        .oscRun(fastOscKeepOn_ff | ~sleepReq), .cellSrc(cellSrc));
    configurable_logic_cell dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff),
        .cellSrc(cellSrc), .sleepReq(sleepReq), .cellOut_ff(cellOut_ff),
        .cellIrqFlag_ff(cellIrqFlag_ff), .fastOscKeepOn_ff(fastOscKeepOn_ff), .cpuIdle_ff(cpuIdle_ff));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1 chk("regRdData_ff", regRdData_ff, e);
    endtask
    // new source levels, then let sync and output stages settle
    task automatic step(input logic [3:0] d, input logic e);
        @(posedge core_clk);
        srcLevel[3:0] <= d;
        repeat (6) @(posedge core_clk);
        #1 chk("cellOut_ff", {7'h0, cellOut_ff}, {7'h0, e});
    endtask
    task automatic t_regs;
        rd(4'h0, 8'h00);
        rd(4'hB, 8'h00);
        for (int i = 2; i < 10; i++) begin
            wr(i[3:0], 8'hFF);
            rd(i[3:0], i < 6 ? 8'h3F : 8'hFF);
        end
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'h8F);
        wr(4'h0, 8'h7F);
        rd(4'h0, 8'h1F);
    endtask
    task automatic t_comb;
        logic [3:0] d;
        logic [2:0] e;
        for (int i = 0; i < 4; i++) begin
            wr(4'h2 + i[3:0], i[7:0]);
            wr(4'h6 + i[3:0], 8'h02 << (2 * i));
        end
        wr(4'h1, 8'h00);
        for (int m = 0; m < 3; m++) begin
            wr(4'h0, 8'h80 | m[7:0]);
            for (int v = 0; v < 16; v++) begin
                d = v[3:0];
                e = {&d, (d[0] | d[1]) ^ (d[2] | d[3]), (d[0] & d[1]) | (d[2] & d[3])};
                step(d, e[m]);
            end
        end
        wr(4'h1, 8'h81);
        step(4'hF, 1'b1);
        wr(4'h6, 8'h00);
        wr(4'h1, 8'h01);
        step(4'hF, 1'b1);
        wr(4'h1, 8'h00);
        step(4'hF, 1'b0);
        wr(4'h6, 8'h02);
    endtask
    // entry: mode in 7:5, expected output in 4, sources in 3:0
    task automatic t_seq;
        logic [7:0] tab [19] = '{8'h71, 8'h70, 8'h64, 8'h82, 8'h93, 8'h90, 8'h81, 8'hA2, 8'hA3,
            8'hAA, 8'hBB, 8'hC2, 8'hD3, 8'hDA, 8'hCB, 8'hE2, 8'hF3, 8'hE1, 8'hF8};
        logic [2:0] m = 3'h0;
        foreach (tab[i]) begin
            if (tab[i][7:5] != m) begin
                m = tab[i][7:5];
                wr(4'h0, 8'h00);
                step(4'h0, 1'b0);
                wr(4'h0, {5'h10, m});
            end
            step(tab[i][3:0], tab[i][4]);
        end
    endtask
    task automatic t_irq;
        wr(4'h0, 8'h80);
        wr(4'h1, 8'h80);
        step(4'h0, 1'b1);
        rd(4'hA, 8'h00);
        wr(4'h0, 8'h90);
        wr(4'h1, 8'h00);
        step(4'h0, 1'b0);
        rd(4'hA, 8'h00);
        wr(4'h1, 8'h80);
        step(4'h0, 1'b1);
        rd(4'hA, 8'h01);
        chk("cellIrqFlag_ff", {7'h0, cellIrqFlag_ff}, 8'h01);
        rd(4'h0, 8'hB0);
        wr(4'hA, 8'h01);
        rd(4'hA, 8'h00);
        chk("cellIrqFlag_ff", {7'h0, cellIrqFlag_ff}, 8'h00);
        wr(4'h0, 8'h08);
        step(4'h0, 1'b0);
        rd(4'hA, 8'h01);
    endtask
    task automatic t_sleep;
        wr(4'h2, 8'h34);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h80);
        step(4'h0, 1'b0);
        chk("fastOscKeepOn_ff", {7'h0, fastOscKeepOn_ff}, 8'h01);
        chk("cpuIdle_ff", {7'h0, cpuIdle_ff}, 8'h00);
        @(posedge core_clk);
        sleepReq <= 1'b1;
        step(4'hC, 1'b1);
        chk("cpuIdle_ff", {7'h0, cpuIdle_ff}, 8'h01);
        wr(4'h0, 8'h00);
        step(4'hC, 1'b0);
        chk("fastOscKeepOn_ff", {7'h0, fastOscKeepOn_ff}, 8'h00);
    endtask
    task automatic t_reset;
        wr(4'h1, 8'h85);
        wr(4'h0, 8'h9A);
        @(posedge core_clk);
        sleepReq <= 1'b0;
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h05);
        rd(4'h2, 8'h34);
        rd(4'h6, 8'h02);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs;
        t_comb;
        t_seq;
        t_irq;
        t_sleep;
        t_reset;
        give_verdict;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict;
        end
    end
endmodule // configurable_logic_cell_tb
`default_nettype wire
